//--- hw/rxcas_consts.vh
// Contract
// - with the 16-code substitution format, replacement A, B, C and D come from bits 3-0 of the timeslot's substitution value register; code: A=bit 0, D=bit 3.
// - substitution format 10 replaces only A and B, taking them from bits 4 and 5 of the substitution value register.
// - substitution format 11 replaces only A, taking it from bit 6 of the substitution value register.
// - extraction scheme 00 extracts no signaling for the timeslot.
// - extraction scheme 01 extracts all four bits A, B, C and D.
// - extraction scheme 10 extracts only A and B (4-code form).
// - extraction scheme 11 extracts only A (2-code form).
// - extracted signaling goes to the signaling array, to the signaling pin when the receive signaling interface is on, and to the overhead pin when its enable is set.
// - there is one substitution value register per timeslot, the lowest address for timeslot 0 and the highest for timeslot 31.
// - there are 32 read-only signaling array registers, bits 7-4 reserved and A, B, C, D in the low bits.
// - substitution changes only the PCM output; the array and the signaling pin keep the received values.
// - substitution format 00 replaces every signaling bit of the timeslot with one on the PCM output.
// - with debounce on, array and pin update only after the same value held for 2 consecutive superframes, otherwise at once.
// - with the overhead enable set the array contents go out on the overhead pin, otherwise nothing goes out there.
`ifndef RXCAS_CONSTS_VH
`define RXCAS_CONSTS_VH

// register indices; byte address is four times the index
`define RXCAS_IDX_CTRL_BASE   12'h3a0
`define RXCAS_IDX_SUBST_BASE  12'h3c0
`define RXCAS_IDX_ARRAY_BASE  12'h500
`define RXCAS_IDX_GLOBAL      12'h3f0

// control register fields
`define RXCAS_CTRL_SUBST_EN   6
`define RXCAS_CTRL_OH_EN      5
`define RXCAS_CTRL_DEB_EN     4
`define RXCAS_CTRL_FMT_HI     3
`define RXCAS_CTRL_FMT_LO     2
`define RXCAS_CTRL_EXT_HI     1
`define RXCAS_CTRL_EXT_LO     0

// substitution value fields
`define RXCAS_SUB16_HI        3
`define RXCAS_SUB4_A          4
`define RXCAS_SUB4_B          5
`define RXCAS_SUB2_A          6

// global register field
`define RXCAS_GLB_SIGIF_EN    0

// codes
`define RXCAS_FMT_ALL_ONES    2'b00
`define RXCAS_FMT_16          2'b01
`define RXCAS_FMT_4           2'b10
`define RXCAS_FMT_2           2'b11
`define RXCAS_EXT_NONE        2'b00
`define RXCAS_EXT_16          2'b01
`define RXCAS_EXT_4           2'b10
`define RXCAS_EXT_2           2'b11

// reset values
`define RXCAS_RST_CTRL        7'h00
`define RXCAS_RST_SUBST       7'h00
`define RXCAS_RST_ARRAY       4'h0
`define RXCAS_RST_GLOBAL      1'b0

// axi responses
`define RXCAS_RESP_OKAY       2'b00
`define RXCAS_RESP_SLVERR     2'b10

`endif

//--- hw/rxcas_top.v
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "rxcas_consts.vh"

module rxcas_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // register bus
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // received stream from the framer, one timeslot per word
  input  wire        in_valid,
  output reg         in_ready,
  input  wire [4:0]  in_ts,
  input  wire [7:0]  in_byte,
  input  wire [3:0]  in_sig,
  input  wire        in_sf,
  // pcm output stream
  output reg         out_valid,
  input  wire        out_ready,
  output reg  [4:0]  out_ts,
  output reg  [7:0]  out_byte,
  output reg  [3:0]  rx_pcm_serial_out,
  // signaling and overhead pins
  output reg  [4:0]  rx_sig_ts,
  output reg  [3:0]  rx_sig_out_pin,
  output reg  [3:0]  rx_overhead_out_pin
);

  // per-timeslot storage and the global interface enable
  reg  [6:0]  ctrl_r      [0:31];
  reg  [6:0]  subst_r     [0:31];
  reg  [3:0]  sig_array_r [0:31];
  reg  [3:0]  sig_prev_r  [0:31];
  reg         sigif_en_r;

  // write channel state
  reg         aw_held_r;
  reg  [11:0] aw_idx_r;
  reg         w_held_r;
  reg  [7:0]  w_data_r;
  reg         w_strb_r;

  // two-entry output buffer, head drives the outputs directly
  reg  [1:0]  cnt_r;
  reg  [4:0]  tl_ts_r;
  reg  [7:0]  tl_byte_r;
  reg  [3:0]  tl_sig_r;

  integer     i;

  // ---------------- register decode ----------------
  // bases sized like the index so every compare matches in width;
  // each 32-entry block starts on a 32-index boundary
  localparam [11:0] CTRL_IDX  = `RXCAS_IDX_CTRL_BASE;
  localparam [11:0] SUBST_IDX = `RXCAS_IDX_SUBST_BASE;
  localparam [11:0] ARRAY_IDX = `RXCAS_IDX_ARRAY_BASE;
  localparam [11:0] GLB_IDX   = `RXCAS_IDX_GLOBAL;

  wire [11:0] ar_idx = s_axi_araddr[13:2];
  wire        ar_hi_zero = (s_axi_araddr[15:14] == 2'b00);
  wire        ar_ctrl  = ar_hi_zero && (ar_idx[11:5] == CTRL_IDX[11:5]);
  wire        ar_subst = ar_hi_zero && (ar_idx[11:5] == SUBST_IDX[11:5]);
  wire        ar_array = ar_hi_zero && (ar_idx[11:5] == ARRAY_IDX[11:5]);
  wire        ar_glb   = ar_hi_zero && (ar_idx == GLB_IDX);
  wire [4:0]  ar_ts    = ar_idx[4:0];

  wire        wr_ctrl  = (aw_idx_r[11:5] == CTRL_IDX[11:5]);
  wire        wr_subst = (aw_idx_r[11:5] == SUBST_IDX[11:5]);
  wire        wr_glb   = (aw_idx_r == GLB_IDX);
  wire [4:0]  wr_ts    = aw_idx_r[4:0];
  wire        wr_go    = aw_held_r && w_held_r && !s_axi_bvalid;

  // ---------------- datapath ----------------
  wire        take      = in_valid && in_ready;
  wire        pop       = out_valid && out_ready;
  wire [6:0]  ts_ctrl   = ctrl_r[in_ts];
  wire [6:0]  ts_subst  = subst_r[in_ts];
  wire [1:0]  fmt       = ts_ctrl[`RXCAS_CTRL_FMT_HI:`RXCAS_CTRL_FMT_LO];
  wire [1:0]  ext       = ts_ctrl[`RXCAS_CTRL_EXT_HI:`RXCAS_CTRL_EXT_LO];
  wire        deb_en    = ts_ctrl[`RXCAS_CTRL_DEB_EN];
  wire [3:0]  arr_cur   = sig_array_r[in_ts];
  wire [3:0]  prev_cur  = sig_prev_r[in_ts];

  // sig vectors hold a at bit 3 down to d at bit 0
  reg  [3:0]  pcm_sig;
  reg  [3:0]  ext_sig;
  reg  [3:0]  arr_nxt;
  reg         arr_upd;

  always @* begin
    pcm_sig = in_sig;
    if (ts_ctrl[`RXCAS_CTRL_SUBST_EN]) begin
      case (fmt)
        `RXCAS_FMT_ALL_ONES: pcm_sig = 4'hf;
        `RXCAS_FMT_16: pcm_sig = {ts_subst[0], ts_subst[1], ts_subst[2],
                                  ts_subst[`RXCAS_SUB16_HI]};
        `RXCAS_FMT_4: pcm_sig = {ts_subst[`RXCAS_SUB4_A], ts_subst[`RXCAS_SUB4_B],
                                 in_sig[1:0]};
        `RXCAS_FMT_2: pcm_sig = {ts_subst[`RXCAS_SUB2_A], in_sig[2:0]};
        default: pcm_sig = in_sig;
      endcase
    end
  end

  // bits dropped by schemes 10 and 11 read as zero in the array; scheme 00 keeps the entry
  always @* begin
    case (ext)
      `RXCAS_EXT_16: ext_sig = in_sig;
      `RXCAS_EXT_4:  ext_sig = {in_sig[3:2], 2'b00};
      `RXCAS_EXT_2:  ext_sig = {in_sig[3], 3'b000};
      default:       ext_sig = arr_cur;
    endcase
  end

  // array sees received bits only, never the substituted ones
  always @* begin
    arr_upd = 1'b0;
    if (take && in_sf && (ext != `RXCAS_EXT_NONE)) begin
      if (deb_en)
        arr_upd = (ext_sig == prev_cur);
      else
        arr_upd = 1'b1;
    end
    arr_nxt = arr_upd ? ext_sig : arr_cur;
  end

  // ---------------- register bus and per-timeslot state ----------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 32; i = i + 1) begin
        ctrl_r[i]      <= `RXCAS_RST_CTRL;
        subst_r[i]     <= `RXCAS_RST_SUBST;
        sig_array_r[i] <= `RXCAS_RST_ARRAY;
        sig_prev_r[i]  <= `RXCAS_RST_ARRAY;
      end
      sigif_en_r    <= `RXCAS_RST_GLOBAL;
      aw_held_r     <= 1'b0;
      aw_idx_r      <= 12'h000;
      w_held_r      <= 1'b0;
      w_data_r      <= 8'h00;
      w_strb_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RXCAS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RXCAS_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end else if (ce) begin
      // ready rises one cycle after reset release and after each response;
      // a pending response refuses the next write, so one write is in flight
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !wr_go &&
                       !s_axi_bvalid;
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !wr_go &&
                       !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[15:14] == 2'b00 ? s_axi_awaddr[13:2] : 12'hfff;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // array space and holes answer slverr, nothing stored
        s_axi_bresp  <= (wr_ctrl || wr_subst || wr_glb) ? `RXCAS_RESP_OKAY
                                                        : `RXCAS_RESP_SLVERR;
        if (w_strb_r && wr_ctrl)
          ctrl_r[wr_ts] <= w_data_r[6:0];
        if (w_strb_r && wr_subst)
          subst_r[wr_ts] <= w_data_r[6:0];
        if (w_strb_r && wr_glb)
          sigif_en_r <= w_data_r[`RXCAS_GLB_SIGIF_EN];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end

      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RXCAS_RESP_OKAY;
        if (ar_ctrl)
          s_axi_rdata <= {25'h0000000, ctrl_r[ar_ts]};
        else if (ar_subst)
          s_axi_rdata <= {25'h0000000, subst_r[ar_ts]};
        else if (ar_array)
          s_axi_rdata <= {28'h0000000, sig_array_r[ar_ts]};
        else if (ar_glb)
          s_axi_rdata <= {31'h00000000, sigif_en_r};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RXCAS_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end

      // superframe samples kept for the two-superframe comparison
      if (take && in_sf) begin
        sig_prev_r[in_ts]  <= ext_sig;
        sig_array_r[in_ts] <= arr_nxt;
      end
    end
  end

  // ---------------- pins ----------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_sig_ts           <= 5'h00;
      rx_sig_out_pin      <= 4'h0;
      rx_overhead_out_pin <= 4'h0;
    end else if (ce && take) begin
      rx_sig_ts           <= in_ts;
      rx_sig_out_pin      <= sigif_en_r ? arr_nxt : 4'h0;
      rx_overhead_out_pin <= ts_ctrl[`RXCAS_CTRL_OH_EN] ? arr_nxt : 4'h0;
    end
  end

  // ---------------- output buffer ----------------
  // two entries so a stalled receiver loses no word; ready is registered,
  // so one slot of headroom is traded for a clean timing path
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r             <= 2'd0;
      in_ready          <= 1'b0;
      out_valid         <= 1'b0;
      out_ts            <= 5'h00;
      out_byte          <= 8'h00;
      rx_pcm_serial_out <= 4'h0;
      tl_ts_r           <= 5'h00;
      tl_byte_r         <= 8'h00;
      tl_sig_r          <= 4'h0;
    end else if (ce) begin
      case ({take, pop})
        2'b10: begin
          if (cnt_r == 2'd0) begin
            out_ts            <= in_ts;
            out_byte          <= in_byte;
            rx_pcm_serial_out <= pcm_sig;
          end else begin
            tl_ts_r   <= in_ts;
            tl_byte_r <= in_byte;
            tl_sig_r  <= pcm_sig;
          end
          cnt_r     <= cnt_r + 2'd1;
          out_valid <= 1'b1;
          in_ready  <= (cnt_r == 2'd0);
        end
        2'b01: begin
          out_ts            <= tl_ts_r;
          out_byte          <= tl_byte_r;
          rx_pcm_serial_out <= tl_sig_r;
          cnt_r     <= cnt_r - 2'd1;
          out_valid <= (cnt_r == 2'd2);
          in_ready  <= 1'b1;
        end
        2'b11: begin
          if (cnt_r == 2'd1) begin
            out_ts            <= in_ts;
            out_byte          <= in_byte;
            rx_pcm_serial_out <= pcm_sig;
          end else begin
            out_ts            <= tl_ts_r;
            out_byte          <= tl_byte_r;
            rx_pcm_serial_out <= tl_sig_r;
            tl_ts_r           <= in_ts;
            tl_byte_r         <= in_byte;
            tl_sig_r          <= pcm_sig;
          end
          in_ready <= (cnt_r == 2'd1);
        end
        default: begin
          in_ready <= (cnt_r != 2'd2);
        end
      endcase
    end
  end

endmodule // rxcas_top

//--- verification/rxcas_props.sv
`timescale 1ns/1ns
module rxcas_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        ce,
  input wire [15:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        in_valid,
  input wire        in_ready,
  input wire [4:0]  in_ts,
  input wire        out_valid,
  input wire        out_ready,
  input wire [3:0]  rx_pcm_serial_out,
  input wire [4:0]  rx_sig_ts,
  input wire [3:0]  rx_sig_out_pin,
  input wire [3:0]  rx_overhead_out_pin
);
  wire take = in_valid & in_ready & ce;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take; take; endsequence
  sequence s_arr_rd; s_axi_arvalid && s_axi_arready && ce && s_axi_araddr[15:7] == 9'h028; endsequence
  property p_ts; s_take |=> rx_sig_ts == $past(in_ts); endproperty
  a_ts: assert property (p_ts) else $error("pin timeslot wrong");
  property p_idle; !take |=> $stable(rx_sig_out_pin) && $stable(rx_overhead_out_pin); endproperty
  a_idle: assert property (p_idle) else $error("pins moved without a word");
  property p_oh; rx_overhead_out_pin != 4'h0 && rx_sig_out_pin != 4'h0 |-> rx_overhead_out_pin == rx_sig_out_pin; endproperty
  a_oh: assert property (p_oh) else $error("overhead pin differs from array");
  property p_arr; s_arr_rd |=> s_axi_rvalid && s_axi_rdata[31:4] == 28'h0; endproperty
  a_arr: assert property (p_arr) else $error("array read reserved bits set");
  property p_rd; s_axi_rvalid && !(s_axi_rready && ce) |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd: assert property (p_rd) else $error("read data dropped early");
  property p_wr; s_axi_bvalid && !(s_axi_bready && ce) |=> s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write response dropped early");
  property p_out; out_valid && !(out_ready && ce) |=> out_valid && $stable(rx_pcm_serial_out); endproperty
  a_out: assert property (p_out) else $error("pcm word dropped early");
  // a refused word must mean a word is waiting downstream
  property p_full; !in_ready && $past(aresetn) |-> out_valid; endproperty
  a_full: assert property (p_full) else $error("input refused while output empty");
  property p_rst; @(posedge aclk) disable iff (1'b0) !aresetn |=> !out_valid && !s_axi_rvalid && rx_sig_out_pin == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // rxcas_props

bind rxcas_top rxcas_props u_rxcas_props (.aclk, .aresetn, .ce, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
  .in_valid, .in_ready, .in_ts, .out_valid, .out_ready, .rx_pcm_serial_out, .rx_sig_ts,
  .rx_sig_out_pin, .rx_overhead_out_pin);

//--- verification/rxcas_sink.sv
`timescale 1ns/1ns
module rxcas_sink (
  input  wire aclk,
  input  wire aresetn,
  input  wire out_valid,
  input  wire hold,
  output reg  out_ready
);
  // random stalls keep the two-entry buffer busy
  always @(posedge aclk) begin
    if (!aresetn)
      out_ready <= 1'b0;
    else
      out_ready <= !hold && ($urandom % 4 != 0);
  end
endmodule // rxcas_sink

//--- verification/tb_top.sv
`timescale 1ns/1ns
`include "rxcas_consts.vh"
module tb_top;
  reg aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0, in_valid = 0, in_sf = 0, hold = 0;
  reg [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0]  s_axi_wstrb = 4'hf, in_sig = 0;
  reg [4:0]  in_ts = 0;
  reg [7:0]  in_byte = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_ready;
  wire out_valid, out_ready;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [4:0] out_ts, rx_sig_ts;
  wire [7:0] out_byte;
  wire [3:0] rx_pcm_serial_out, rx_sig_out_pin, rx_overhead_out_pin;
  integer num_errors = 0, num_checks = 0, cyc = 0, i, k;
  reg [6:0] ctl [0:31], sub [0:31], c, s;
  reg [3:0] arr [0:31], prv [0:31], p, e;
  reg glb = 0, pend = 0, low_seen;
  reg [12:0] epin;
  reg [16:0] q [$];

  always #2 aclk = ~aclk;
  rxcas_top u_rxcas_top (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .in_valid, .in_ready, .in_ts, .in_byte, .in_sig, .in_sf,
    .out_valid, .out_ready, .out_ts, .out_byte, .rx_pcm_serial_out, .rx_sig_ts,
    .rx_sig_out_pin, .rx_overhead_out_pin);
  rxcas_sink u_rxcas_sink (.aclk, .aresetn, .out_valid, .hold, .out_ready);

  task automatic chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  function [15:0] ad(input [15:0] b, input integer t);
    ad = b + {t[4:0], 2'b00};
  endfunction

  task wr(input [15:0] a, input [31:0] d, input [1:0] er);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (!(s_axi_bvalid === 1'b1 && ce)) begin
        if (s_axi_awready === 1'b1 && ce) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1 && ce) s_axi_wvalid <= 1'b0;
        @(posedge aclk);
      end
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task rd(input [15:0] a, input [31:0] ed, input [1:0] er);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!(s_axi_rvalid === 1'b1 && ce)) begin
        if (s_axi_arready === 1'b1 && ce) s_axi_arvalid <= 1'b0;
        @(posedge aclk);
      end
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task cfg(input integer t, input [6:0] cv, input [6:0] sv);
    begin
      wr(ad(16'he80, t), cv, `RXCAS_RESP_OKAY);
      wr(ad(16'hf00, t), sv, `RXCAS_RESP_OKAY);
      rd(ad(16'he80, t), cv, `RXCAS_RESP_OKAY);
      ctl[t] = cv;
      sub[t] = sv;
    end
  endtask

  task setg(input g);
    begin
      wr(16'hfc0, g, `RXCAS_RESP_OKAY);
      rd(16'hfc0, g, `RXCAS_RESP_OKAY);
      glb = g;
    end
  endtask

  task rst;
    begin
      aresetn <= 1'b0;
      ce <= 1'b1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 32; i = i + 1) begin
        ctl[i] = 0;
        sub[i] = 0;
        arr[i] = 0;
        prv[i] = 0;
      end
      glb = 0;
      q.delete();
      repeat (2) @(posedge aclk);
    end
  endtask

  // ce toggles too, since a frozen cycle must not take a word
  task send(input integer t, input sf, input [3:0] g);
    begin
      in_valid <= 1'b1;
      in_ts <= t[4:0];
      in_byte <= $urandom;
      in_sig <= g;
      in_sf <= sf;
      ce <= ($urandom % 8) != 0;
      @(posedge aclk);
      while (!(in_ready === 1'b1 && ce)) begin
        ce <= ($urandom % 8) != 0;
        @(posedge aclk);
      end
    end
  endtask

  task finish_burst;
    begin
      in_valid <= 1'b0;
      ce <= 1'b1;
      repeat (40) @(posedge aclk);
      chk(q.size(), 0);
      for (k = 0; k < 32; k = k + 1)
        rd(ad(16'h1400, k), arr[k], `RXCAS_RESP_OKAY);
    end
  endtask

  task model;
    begin
      c = ctl[in_ts];
      s = sub[in_ts];
      case (c[3:2])
        2'b00: p = 4'hf;
        2'b01: p = {s[0], s[1], s[2], s[3]};
        2'b10: p = {s[4], s[5], in_sig[1:0]};
        default: p = {s[6], in_sig[2:0]};
      endcase
      if (!c[6]) p = in_sig;
      q.push_back({in_ts, in_byte, p});
      if (in_sf) begin
        case (c[1:0])
          2'b01: e = in_sig;
          2'b10: e = {in_sig[3:2], 2'b00};
          2'b11: e = {in_sig[3], 3'b000};
          default: e = arr[in_ts];
        endcase
        // debounce compares extracted values, so unextracted bits never block it
        if (!c[4] || e == prv[in_ts]) arr[in_ts] = e;
        prv[in_ts] = e;
      end
      pend = 1'b1;
      epin = {in_ts, glb ? arr[in_ts] : 4'h0, c[5] ? arr[in_ts] : 4'h0};
    end
  endtask

  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
    if (aresetn) begin
      if (!in_ready) low_seen = 1'b1;
      if (pend) chk({rx_sig_ts, rx_sig_out_pin, rx_overhead_out_pin}, epin);
      pend = 1'b0;
      if (out_valid && out_ready && ce)
        chk({out_ts, out_byte, rx_pcm_serial_out}, q.pop_front());
      if (in_valid && in_ready && ce) model;
    end
  end

  initial begin
    k = $urandom(32'hf58fdbaa);
    rst;
    for (i = 0; i < 32; i = i + 31) begin
      rd(ad(16'he80, i), 0, `RXCAS_RESP_OKAY);
      rd(ad(16'h1400, i), 0, `RXCAS_RESP_OKAY);
      wr(ad(16'h1400, i), 32'hf, `RXCAS_RESP_SLVERR);
      rd(ad(16'hf00, i), 0, `RXCAS_RESP_OKAY);
      wr(ad(16'hf00, i), 32'hffffffff, `RXCAS_RESP_OKAY);
      rd(ad(16'hf00, i), 32'h7f, `RXCAS_RESP_OKAY);
    end
    rd(16'h0000, 0, `RXCAS_RESP_SLVERR);
    $display("register map test done");
    rst;
    setg(1'b1);
    for (i = 0; i < 16; i = i + 1)
      cfg(i, {1'b1, i[0], 1'b0, i[3:0]}, $urandom);
    cfg(16, 7'h21, 7'h7f);
    for (i = 0; i < 64; i = i + 1)
      send(i, 1'b1, $urandom);
    finish_burst;
    $display("code table test done");
    rst;
    setg(1'b1);
    cfg(5, 7'h11, 7'h00);
    for (i = 0; i < 6; i = i + 1)
      send(5, i != 1, 24'haa6939 >> (4 * i));
    finish_burst;
    $display("debounce test done");
    rst;
    setg($urandom % 2);
    for (i = 0; i < 32; i = i + 1) begin
      c = $urandom;
      cfg(i, c, $urandom);
    end
    hold <= 1'b1;
    low_seen = 1'b0;
    fork
      begin
        repeat (30) @(posedge aclk);
        hold <= 1'b0;
      end
    join_none
    for (i = 0; i < 200; i = i + 1)
      send($urandom, $urandom, $urandom);
    chk(low_seen, 1);
    finish_burst;
    $display("stall and random test done");
    tally_and_finish;
  end
endmodule // tb_top
